// >>> core/hwm_params.svh
// Constants of the hardware-monitor conversion sequencer.
// Assumes inclusion by the package and by the sequencer files.
`ifndef HWM_PARAMS_SVH
`define HWM_PARAMS_SVH

`define HWM_CLK_HZ        100000000
`define HWM_CONV_HZ       45000
`define HWM_DIV_CYCLES    (`HWM_CLK_HZ / `HWM_CONV_HZ)
`define HWM_IDLE_MS       1000
`define HWM_IDLE_TICKS    ((`HWM_IDLE_MS * `HWM_CONV_HZ) / 1000)
`define HWM_TEMP_CLKS     7'd96
`define HWM_VOLT_CLKS     7'd68
`define HWM_NUM_INPUTS    8
`define HWM_LAST_INPUT    3'd7

`define HWM_OFS_READING   8'h20
`define HWM_OFS_RLS       8'h40
`define HWM_OFS_STATUS1   8'h41
`define HWM_OFS_STATUS2   8'h42
`define HWM_OFS_LIMIT     8'h44
`define HWM_OFS_SFR       8'h7c
`define HWM_OFS_CONFIG    8'h7f

`define HWM_RLS_START     0
`define HWM_RLS_LOCK      1
`define HWM_RLS_READY     2
`define HWM_SFR_MODE      1
`define HWM_SFR_GLOBAL_INTERRUPT_ENABLE     2
`define HWM_CFG_SOFT_RST  7

`define HWM_SFR_RESET     8'h40
`define HWM_CFG_RESET     8'h00
`define HWM_LOW_RESET     8'h00
`define HWM_HIGH_RESET    8'hff
`define HWM_FAULT_READING 8'h80

`endif

// >>> core/hwm_pkg.sv
// Types shared by the hardware-monitor conversion sequencer.
// Assumes the constants header sits beside it.
`include "hwm_params.svh"

package hwm_pkg;
  typedef enum logic [2:0] {
    HWM_ST_IDLE = 3'b001,
    HWM_ST_CONV = 3'b010,
    HWM_ST_WAIT = 3'b100
  } hwm_state_t;
endpackage

// >>> core/hwm_avg.sv
// Accumulator that turns a run of raw conversions into one mean.
// Assumes counts are powers of two, given as a shift of at most 7.
`timescale 1ns/1ps

module hwm_avg (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       clr,
  input  wire logic       add_en,
  input  wire logic       last,
  input  wire logic [7:0] sample,
  input  wire logic [2:0] shift,
  output logic      [7:0] mean
);
  logic [14:0] acc_reg;
  logic [14:0] acc_next;

  // Summing the final sample here lets the mean leave in the same cycle.
  assign acc_next = acc_reg + {7'h00, sample};
  assign mean     = 8'(acc_next >> shift);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_reg <= 15'h0000;
    end else if (clr || (add_en && last)) begin
      acc_reg <= 15'h0000;
    end else if (add_en) begin
      acc_reg <= acc_next;
    end
  end
endmodule

// >>> core/hwm_seq.sv
// Conversion sequencer of a hardware-monitoring block, with its registers.
// Assumes a byte-wide register port driven by a bus engine, and an analog
// front end that presents the current input's raw result on adc_data.
`timescale 1ns/1ps
`include "hwm_params.svh"
module hwm_seq
  import hwm_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = `HWM_DIV_CYCLES,
  parameter int unsigned IDLE_TICKS = `HWM_IDLE_TICKS
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] adc_data,
  input  wire logic [1:0] diode_fault,
  output logic      [2:0] adc_channel,
  output logic            converting
);
  hwm_state_t  state_reg;
  logic [11:0] div_reg;
  logic        tick;
  logic [6:0]  tick_cnt_reg;
  logic [7:0]  nconv_reg;
  logic [15:0] idle_reg;
  logic [2:0]  ch_reg;
  logic [7:0]  rls_reg;
  logic [7:0]  sfr_reg;
  logic [7:0]  cfg_reg;
  logic        soft_rst_reg;
  logic [7:0]  status1_reg;
  logic [1:0]  status2_reg;
  logic [7:0]  cond1_reg;
  logic [1:0]  cond2_reg;
  logic [7:0]  reading [`HWM_NUM_INPUTS];
  logic [7:0]  low_lim [`HWM_NUM_INPUTS];
  logic [7:0]  high_lim [`HWM_NUM_INPUTS];
  logic        remote;
  logic        is_temp;
  logic [6:0]  conv_len;
  logic [2:0]  shift;
  logic [7:0]  nconv_last;
  logic        conv_end;
  logic        chan_done;
  logic [7:0]  sample;
  logic [7:0]  mean;
  logic        start;
  logic        wr_ok;
  logic [7:0]  lim_idx;

  assign start   = rls_reg[`HWM_RLS_START];
  assign remote  = (ch_reg == 3'd0) || (ch_reg == `HWM_LAST_INPUT);
  assign is_temp = remote || (ch_reg == 3'd1);
  assign conv_len = is_temp ? `HWM_TEMP_CLKS : `HWM_VOLT_CLKS;
  assign wr_ok   = reg_wr && !soft_rst_reg;
  assign lim_idx = reg_addr - `HWM_OFS_LIMIT;

  // Averaging count as a power-of-two shift.
  always_comb begin
    casez (sfr_reg[7:5])
      3'b1??:  shift = 3'd5;
      3'b01?:  shift = 3'd4;
      3'b001:  shift = remote ? 3'd4 : 3'd0;
      default: shift = remote ? 3'd7 : 3'd3;
    endcase
  end
  assign nconv_last = 8'((9'h001 << shift) - 9'h001);

  // A shorted diode reads as the fault code 80h, which trips the limit check only where the limits exclude 80h.
  assign sample = (remote && diode_fault[ch_reg == 3'd0 ? 0 : 1]) ?
                  `HWM_FAULT_READING : adc_data;

  assign conv_end  = (state_reg == HWM_ST_CONV) && tick &&
                     (tick_cnt_reg == conv_len - 7'd1);
  assign chan_done = conv_end && (nconv_reg == nconv_last);

  hwm_avg u_avg (
    .mclk   (mclk),
    .rstn   (rstn),
    .clr    (state_reg == HWM_ST_IDLE),
    .add_en (conv_end),
    .last   (chan_done),
    .sample (sample),
    .shift  (shift),
    .mean   (mean)
  );

  // Conversion clock; free running so its phase never depends on software.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 12'h000;
      tick    <= 1'b0;
    end else if (div_reg == 12'(DIV_CYCLES - 1)) begin
      div_reg <= 12'h000;
      tick    <= 1'b1;
    end else begin
      div_reg <= div_reg + 12'h001;
      tick    <= 1'b0;
    end
  end

  // Sequencer.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= HWM_ST_IDLE;
      tick_cnt_reg <= 7'h00;
      nconv_reg    <= 8'h00;
      idle_reg     <= 16'h0000;
      ch_reg       <= 3'h0;
    end else if (soft_rst_reg || !start) begin
      state_reg    <= HWM_ST_IDLE;
      tick_cnt_reg <= 7'h00;
      nconv_reg    <= 8'h00;
      idle_reg     <= 16'h0000;
      ch_reg       <= 3'h0;
    end else begin
      case (state_reg)
        HWM_ST_IDLE: begin
          state_reg <= HWM_ST_CONV;
        end
        HWM_ST_CONV: begin
          if (chan_done) begin
            tick_cnt_reg <= 7'h00;
            nconv_reg    <= 8'h00;
            ch_reg       <= ch_reg + 3'd1;
            if (ch_reg == `HWM_LAST_INPUT &&
                sfr_reg[`HWM_SFR_MODE]) begin
              state_reg <= HWM_ST_WAIT;
            end
          end else if (conv_end) begin
            tick_cnt_reg <= 7'h00;
            nconv_reg    <= nconv_reg + 8'h01;
          end else if (tick) begin
            tick_cnt_reg <= tick_cnt_reg + 7'h01;
          end
        end
        HWM_ST_WAIT: begin
          if (tick) begin
            if (idle_reg == 16'(IDLE_TICKS - 1)) begin
              idle_reg  <= 16'h0000;
              state_reg <= HWM_ST_CONV;
            end else begin
              idle_reg <= idle_reg + 16'h0001;
            end
          end
        end
        default: begin
          state_reg <= HWM_ST_IDLE;
        end
      endcase
    end
  end

  // Readings are never reset, so their power-up value is undefined.
  always_ff @(posedge mclk) begin
    if (chan_done) begin
      reading[ch_reg] <= mean;
    end
  end

  // Control registers and limits; soft reset reaches all of them.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rls_reg      <= 8'h00;
      sfr_reg      <= `HWM_SFR_RESET;
      cfg_reg      <= `HWM_CFG_RESET;
      soft_rst_reg <= 1'b0;
      for (int i = 0; i < `HWM_NUM_INPUTS; i++) begin
        low_lim[i]  <= `HWM_LOW_RESET;
        high_lim[i] <= `HWM_HIGH_RESET;
      end
    end else if (soft_rst_reg) begin
      rls_reg      <= 8'h00;
      sfr_reg      <= `HWM_SFR_RESET;
      cfg_reg      <= `HWM_CFG_RESET;
      soft_rst_reg <= 1'b0;
      for (int i = 0; i < `HWM_NUM_INPUTS; i++) begin
        low_lim[i]  <= `HWM_LOW_RESET;
        high_lim[i] <= `HWM_HIGH_RESET;
      end
    end else begin
      if (chan_done && ch_reg == `HWM_LAST_INPUT) begin
        rls_reg[`HWM_RLS_READY] <= 1'b1;
      end
      if (wr_ok) begin
        case (reg_addr)
          `HWM_OFS_RLS: begin
            rls_reg[`HWM_RLS_START] <= reg_wdata[`HWM_RLS_START];
            rls_reg[`HWM_RLS_LOCK]  <= reg_wdata[`HWM_RLS_LOCK];
          end
          `HWM_OFS_SFR: begin
            sfr_reg <= reg_wdata;
          end
          `HWM_OFS_CONFIG: begin
            cfg_reg      <= {1'b0, reg_wdata[6:0]};
            soft_rst_reg <= reg_wdata[`HWM_CFG_SOFT_RST];
          end
          default: begin
            if (lim_idx < 8'(2 * `HWM_NUM_INPUTS)) begin
              if (lim_idx[0]) begin
                high_lim[lim_idx[3:1]] <= reg_wdata;
              end else begin
                low_lim[lim_idx[3:1]] <= reg_wdata;
              end
            end
          end
        endcase
      end
    end
  end

  // Status bits: a new event in the clearing read's cycle still lands.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status1_reg <= 8'h00;
      status2_reg <= 2'b00;
      cond1_reg   <= 8'h00;
      cond2_reg   <= 2'b00;
    end else if (soft_rst_reg) begin
      status1_reg <= 8'h00;
      status2_reg <= 2'b00;
      cond1_reg   <= 8'h00;
      cond2_reg   <= 2'b00;
    end else begin
      logic [7:0] set1;
      logic [1:0] set2;
      logic [7:0] keep1;
      logic [1:0] keep2;
      set1  = 8'h00;
      set2  = 2'b00;
      keep1 = status1_reg;
      keep2 = status2_reg;
      if (reg_rd && reg_addr == `HWM_OFS_STATUS1) begin
        keep1 = status1_reg & cond1_reg;
      end
      if (reg_rd && reg_addr == `HWM_OFS_STATUS2) begin
        keep2 = status2_reg & cond2_reg;
      end
      if (chan_done) begin
        set1[ch_reg] = (mean > high_lim[ch_reg]) ||
                       (mean < low_lim[ch_reg]);
        cond1_reg[ch_reg] <= set1[ch_reg];
        if (remote) begin
          set2[ch_reg == 3'd0 ? 0 : 1] = diode_fault[ch_reg == 3'd0 ? 0 : 1];
          cond2_reg[ch_reg == 3'd0 ? 0 : 1] <=
            diode_fault[ch_reg == 3'd0 ? 0 : 1];
        end
      end
      status1_reg <= keep1 | set1;
      status2_reg <= keep2 | set2;
    end
  end

  // Registered read port; undefined offsets return zero.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr >= `HWM_OFS_READING &&
          reg_addr < `HWM_OFS_READING + 8'(`HWM_NUM_INPUTS)) begin
        reg_rdata <= reading[reg_addr[2:0]];
      end else if (lim_idx < 8'(2 * `HWM_NUM_INPUTS)) begin
        reg_rdata <= lim_idx[0] ? high_lim[lim_idx[3:1]] :
                                  low_lim[lim_idx[3:1]];
      end else begin
        case (reg_addr)
          `HWM_OFS_RLS:     reg_rdata <= rls_reg;
          `HWM_OFS_STATUS1: reg_rdata <= status1_reg;
          `HWM_OFS_STATUS2: reg_rdata <= {6'h00, status2_reg};
          `HWM_OFS_SFR:     reg_rdata <= sfr_reg;
          `HWM_OFS_CONFIG:  reg_rdata <= cfg_reg;
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      adc_channel <= 3'h0;
      converting  <= 1'b0;
    end else begin
      adc_channel <= ch_reg;
      converting  <= (state_reg == HWM_ST_CONV);
    end
  end

  stay_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    !start |=> state_reg == HWM_ST_IDLE)
    else $error("sequencer left idle without start");
  soft_abort_a: assert property (@(posedge mclk) disable iff (!rstn)
    soft_rst_reg |=> state_reg == HWM_ST_IDLE && !start && !soft_rst_reg)
    else $error("soft reset did not abort and self-clear");
  avg_reset_a: assert property (@(posedge mclk) disable iff (!rstn)
    soft_rst_reg |=> sfr_reg[7:5] == 3'b010)
    else $error("averaging field not restored to 010");
  conv_len_a: assert property (@(posedge mclk) disable iff (!rstn)
    conv_end |-> tick_cnt_reg == (is_temp ? 7'd95 : 7'd67))
    else $error("conversion length wrong");
  avg_prio_a: assert property (@(posedge mclk) disable iff (!rstn)
    (conv_end && sfr_reg[7]) |-> nconv_last == 8'd31)
    else $error("top averaging bit did not force 32");
  seq_order_a: assert property (@(posedge mclk) disable iff (!rstn)
    (chan_done && start && !soft_rst_reg) |=>
      ch_reg == $past(ch_reg) + 3'd1)
    else $error("input order broken");
  cycle_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    (chan_done && start && !soft_rst_reg && ch_reg == 3'd7) |=>
      state_reg == (sfr_reg[1] ? HWM_ST_WAIT : HWM_ST_CONV))
    else $error("mode after last input wrong");
  read_update_a: assert property (@(posedge mclk) disable iff (!rstn)
    chan_done |=> reading[$past(ch_reg)] == $past(mean))
    else $error("reading not updated with mean");
  status_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    (!reg_rd && !soft_rst_reg) |=>
      (status1_reg & $past(status1_reg)) == $past(status1_reg))
    else $error("status bit dropped without a read");
endmodule

// >>> test/test_hwm_seq.sv
// Self-checking bench for the conversion sequencer and its register port.
// Assumes the sequencer is built with short tick and idle counts.
`timescale 1ns/1ps

module test_hwm_seq;
  localparam int DIV = 2;
  localparam int IDL = 3;
  logic        mclk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  adc_data;
  logic [1:0]  diode_fault;
  logic [2:0]  adc_channel;
  logic        converting;
  logic [15:0] exp_q[$];
  logic [15:0] ex;
  logic [7:0]  exp_rd[8];
  logic [7:0]  pend[8];
  logic [2:0]  code;
  logic [2:0]  ch_q;
  logic        rd_d;
  logic        cont_chk;
  logic        quiet;
  int          mismatches;
  int          samples_checked;
  int          seed;
  int          cyc;
  int          t_in;
  int          cnt;
  int          e_span;
  event        enter_ev;

  hwm_seq #(.DIV_CYCLES(DIV), .IDLE_TICKS(IDL)) u_hwm_seq (
    .mclk(mclk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .adc_data(adc_data),
    .diode_fault(diode_fault),
    .adc_channel(adc_channel),
    .converting(converting)
  );

  function automatic int n_of(logic [2:0] k, logic [2:0] c);
    logic rem;
    rem = (c == 3'd0) || (c == 3'd7);
    if (k[2]) return 32;
    if (k[1]) return 16;
    if (k[0]) return rem ? 16 : 1;
    return rem ? 128 : 8;
  endfunction

  function automatic int len_of(logic [2:0] c);
    return (c <= 3'd1 || c == 3'd7) ? 96 : 68;
  endfunction

  task automatic check8(string what, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic check_span(string what, int e, int s, int tol);
    samples_checked++;
    if (s < e - tol || s > e + tol) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", what, e, s);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reset_vals();
    logic [7:0] a[8];
    logic [7:0] v[8];
    a = '{8'h40, 8'h41, 8'h42, 8'h7c, 8'h7f, 8'h44, 8'h45, 8'h30};
    v = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'hff, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(a[i], v[i]);
    end
  endtask

  task automatic rd_readings();
    for (int i = 0; i < 8; i++) begin
      rd(8'h20 + 8'(i), exp_rd[i]);
    end
  endtask

  task automatic go(logic [7:0] sfr);
    code = sfr[7:5];
    wr(8'h7c, sfr);
    wr(8'h40, 8'h01);
    -> enter_ev;
  endtask

  task automatic srst();
    quiet = 1'b1;
    cont_chk = 1'b0;
    wr(8'h7f, 8'h80);
    // The abort moves the channel back to 0, which is not a sequence step.
    repeat (6) @(posedge mclk);
    check8("converting", 8'h00, {7'h0, converting});
    quiet = 1'b0;
  endtask

  task automatic wait_ch(logic [2:0] c);
    do begin
      @(enter_ev);
    end while (ch_q !== c);
  endtask

  task automatic drive_in(logic [2:0] c);
    int n;
    int sum;
    int wt;
    logic [7:0] v;
    n = n_of(code, c);
    sum = 0;
    // A soft reset abandons the run, so the next start finds this idle.
    for (int k = 0; k < n && !quiet; k++) begin
      v = {1'b0, 7'($random(seed))};
      adc_data <= v;
      sum += v;
      // Values change mid-conversion, clear of every sampling instant.
      if (k < n - 1) begin
        wt = len_of(c) * DIV * (k == 0 ? 3 : 2) / 2;
        for (int w = 0; w < wt && !quiet; w++) begin
          @(posedge mclk);
        end
      end
    end
    pend[c] = 8'(sum / n);
    if ((c == 3'd0 && diode_fault[0]) || (c == 3'd7 && diode_fault[1])) begin
      pend[c] = 8'h80;
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      ex = exp_q.pop_front();
      check8($sformatf("reg %h", ex[15:8]), ex[7:0], reg_rdata);
    end
    if (cont_chk) begin
      check8("converting", 8'h01, {7'h0, converting});
    end
    if (rstn === 1'b1 && adc_channel !== ch_q) begin
      if (!quiet) begin
        check8("channel", {5'h0, ch_q + 3'd1}, {5'h0, adc_channel});
        exp_rd[ch_q] = pend[ch_q];
        e_span = n_of(code, ch_q) * len_of(ch_q) * DIV;
        if (ch_q inside {[3'd1:3'd6]}) begin
          check_span("span", e_span, cyc - t_in, 2);
        end
      end
      ch_q = adc_channel;
      t_in = cyc;
      // The abort's jump back to input 0 starts no conversion run.
      if (!quiet) begin
        -> enter_ev;
      end
    end
  end

  initial begin
    forever begin
      @(enter_ev);
      drive_in(ch_q);
    end
  end

  initial begin
    repeat (95000) @(posedge mclk);
    mismatches++;
    $display("BAD watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    adc_data = 8'h00;
    diode_fault = 2'b00;
    rd_d = 1'b0;
    cont_chk = 1'b0;
    quiet = 1'b0;
    ch_q = 3'd0;
    code = 3'b010;
    mismatches = 0;
    samples_checked = 0;
    seed = 76;
    cyc = 0;
    t_in = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    reset_vals();
    repeat (200) @(posedge mclk);
    check8("converting", 8'h00, {7'h0, converting});
    $display("test reset done");
    wr(8'h4a, 8'hff);
    wr(8'h23, 8'h55);
    diode_fault <= 2'b10;
    go(8'h20);
    rd(8'h7c, 8'h20);
    cont_chk = 1'b1;
    wait_ch(0);
    repeat (4) @(posedge mclk);
    rd_readings();
    rd(8'h40, 8'h05);
    rd(8'h42, 8'h02);
    rd(8'h41, 8'h08);
    rd(8'h41, 8'h08);
    wr(8'h4a, 8'h00);
    wait_ch(4);
    rd(8'h41, 8'h08);
    rd(8'h41, 8'h00);
    $display("test continuous done");
    diode_fault <= 2'b00;
    srst();
    reset_vals();
    rd_readings();
    repeat (300) @(posedge mclk);
    check8("converting", 8'h00, {7'h0, converting});
    $display("test soft reset done");
    go(8'h22);
    wait_ch(7);
    while (converting === 1'b1) begin
      @(posedge mclk);
    end
    cnt = 0;
    while (converting !== 1'b1) begin
      @(posedge mclk);
      cnt++;
    end
    check_span("idle", IDL * DIV, cnt, DIV + 2);
    $display("test cycle done");
    srst();
    go(8'he0);
    wait_ch(2);
    rd(8'h20, exp_rd[0]);
    rd(8'h21, exp_rd[1]);
    srst();
    go(8'h60);
    wait_ch(3);
    rd(8'h20, exp_rd[0]);
    rd(8'h21, exp_rd[1]);
    srst();
    go(8'h00);
    wait_ch(2);
    rd(8'h20, exp_rd[0]);
    rd(8'h21, exp_rd[1]);
    srst();
    $display("test averaging done");
    end_sim();
  end
endmodule
